// >>> bench/prp_bus_park_bench.sv
// Self-checking bench for the primary-bus reset and parking block.
// Assumes the checker is bound and the partner target is compiled.
`timescale 1ns/1ps
`default_nettype none
`include "prp_regs.vh"
// ==============================================
// Bench
// ==============================================
module prp_bus_park_bench;
    logic clk = 0, rst_b = 1, cpu_bus_request_n = 1, mst_start = 0;
    logic mst_write = 0, tb_frame = 1, tb_irdy = 1, mute = 0;
    logic [1:0] master_request_n = 2'h3;
    logic [2:0] lag = 3'h0;
    logic [3:0] mst_cmd = 4'h0, mst_be_n = 4'hf, tb_cbe = 4'hf;
    logic [31:0] mst_addr = 0, mst_wdata = 0, tb_ad = 32'h5a5aa5a5;
    logic [31:0] ad_in, ad_out, mst_rdata, tgt_word, p_rd, p_a, p_d;
    logic [3:0] cbe_in, cbe_out, p_c;
    logic ad_oe_n, cbe_oe_n, frame_in, frame_out, frame_oe_n, irdy_in;
    logic irdy_out, irdy_oe_n, trdy_in, trdy_out, trdy_oe_n, stop_in;
    logic stop_out, stop_oe_n, devsel_in, devsel_out, devsel_oe_n;
    logic memory_request_n, memory_request_oe_n, cpu_bus_grant_oe_n;
    logic grant0_or_bridge_request_n, bridge_own_grant_n, mst_busy;
    logic mst_done, mst_abort, tgt_wr, arb_enabled, p_trdy, p_dev, p_drv;
    int mismatches = 0, checked = 0;
    // Wire levels from all parties; released control lines pull high.
    assign frame_in = frame_oe_n ? tb_frame : frame_out;
    assign irdy_in = irdy_oe_n ? tb_irdy : irdy_out;
    assign trdy_in = trdy_oe_n ? p_trdy : trdy_out;
    assign devsel_in = devsel_oe_n ? p_dev : devsel_out;
    assign stop_in = stop_oe_n | stop_out;
    assign ad_in = !ad_oe_n ? ad_out : p_drv ? p_rd : tb_ad;
    assign cbe_in = !cbe_oe_n ? cbe_out : tb_cbe;
    assign bridge_own_grant_n = grant0_or_bridge_request_n;
    always #25 clk = ~clk;
    prp_bus_park u_dut (.*, .par_out(), .par_oe_n(), .flush_request_n(),
        .flush_request_oe_n(), .cpu_bus_grant_n(), .grant1_or_resume_n(),
        .grant0_or_bridge_request_oe_n(), .grant1_or_resume_oe_n());
    prp_far_tgt u_far (.clk(clk), .frame_n(frame_oe_n | frame_out),
        .irdy_n(irdy_in), .ad(ad_in), .cbe(cbe_in), .mute(mute),
        .lag(lag), .trdy_n(p_trdy), .devsel_n(p_dev), .drv(p_drv),
        .rd(p_rd), .got_addr(p_a), .got_data(p_d), .got_cmd(p_c));
    task automatic chk(input string w, input logic [35:0] s, e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic give_verdict;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic do_reset(input logic strap);
        @(posedge clk);
        rst_b <= 0;
        cpu_bus_request_n <= strap;
        repeat (21) @(posedge clk);
        #1 chk("reset drive", {ad_oe_n, cbe_oe_n, ad_out}, 0);
        chk("reset float", {frame_oe_n, cpu_bus_grant_oe_n}, 2'h3);
        chk("word reset", tgt_word, 0);
        @(posedge clk);
        rst_b <= 1;
        repeat (7) @(posedge clk);
        #1 chk("strap", arb_enabled, strap);
        chk("requests", {memory_request_oe_n, memory_request_n}, 1);
        chk("park", ad_oe_n, !strap);
        $display("reset test done");
    endtask
    task automatic mst(input logic wr, input logic [31:0] a, d,
                       output logic [31:0] r, output logic ab);
        int n;
        @(posedge clk);
        {mst_start, mst_write, mst_addr} <= {1'b1, wr, a};
        {mst_wdata, mst_be_n} <= {d, 4'h0};
        mst_cmd <= wr ? `PRP_CMD_MWR : `PRP_CMD_MRD;
        @(posedge clk);
        mst_start <= 0;
        #1 for (n = 0; n < 40 && mst_done !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk("done", mst_done, 1);
        chk("busy", mst_busy, 1);
        r = mst_rdata;
        ab = mst_abort;
    endtask
    task automatic tgt(input logic [3:0] c, b, input logic [31:0] d,
                       output logic [31:0] g);
        int n;
        repeat (3) @(posedge clk); // Let the last owner release the bus.
        {tb_frame, tb_ad, tb_cbe} <= {1'b0, `PRP_TGT_BASE, c};
        @(posedge clk);
        {tb_frame, tb_irdy, tb_ad, tb_cbe} <= {2'b10, d, b};
        #1 for (n = 0; n < 20 && trdy_in !== 1'b0; n++) begin
            @(posedge clk);
            #1;
        end
        chk("cbe monitored", cbe_oe_n, 1);
        g = ad_in;
        @(posedge clk);
        {tb_irdy, tb_ad, tb_cbe} <= {1'b1, ~d, 4'hf};
    endtask
    task automatic t_master;
        logic [31:0] r;
        logic ab;
        mst(1, 32'h12345677, 32'hcafef00d, r, ab);
        chk("abort", ab, 0);
        chk("address", p_a, 32'h12345674);
        chk("wdata", p_d, 32'hcafef00d);
        chk("command", p_c, `PRP_CMD_MWR);
        lag <= 3'h2;
        mst(0, 32'h00002000, 0, r, ab);
        chk("rdata", r, 32'h00002011);
        lag <= 3'h0;
        $display("master test done");
    endtask
    task automatic t_abort;
        logic [31:0] r;
        logic ab;
        mute <= 1;
        mst(1, 32'h00003000, 32'h1, r, ab);
        chk("no devsel abort", ab, 1);
        mute <= 0;
        $display("abort test done");
    endtask
    task automatic t_target;
        logic [31:0] g;
        tgt(`PRP_CMD_MWR, 4'b1010, 32'h44332211, g);
        #1 chk("merge", tgt_word, 32'h00330011);
        chk("write pulse", tgt_wr, 1);
        tgt(`PRP_CMD_MRD, 4'h0, 32'h0, g);
        chk("target read", g, 32'h00330011);
        $display("target test done");
    endtask
    // Watchdog cuts a hang short after about 4000 clocks.
    initial begin
        #200000;
        mismatches++;
        give_verdict;
    end
    // Main sequence.
    initial begin
        rst_b <= 0; // Reset is held from time zero.
        do_reset(1);
        t_master;
        do_reset(0);
        t_abort;
        t_target;
        do_reset(1);
        give_verdict;
    end
endmodule // prp_bus_park_bench
`default_nettype wire

// >>> bench/prp_bus_park_chk.sv
// Port checker for the primary-bus reset and parking block.
// Assumes it is bound into every prp_bus_park instance.
`timescale 1ns/1ps
`default_nettype none
// ==============================================
// Checker
// ==============================================
module prp_bus_park_chk (
    // Clock and reset.
    input wire logic        clk,
    input wire logic        rst_b,
    // Watched outputs and straps.
    input wire logic [31:0] ad_out,
    input wire logic        ad_oe_n,
    input wire logic        cbe_oe_n,
    input wire logic        frame_out,
    input wire logic        frame_oe_n,
    input wire logic        irdy_oe_n,
    input wire logic        devsel_oe_n,
    input wire logic        memory_request_n,
    input wire logic        memory_request_oe_n,
    input wire logic        cpu_bus_request_n,
    input wire logic        bridge_own_grant_n,
    input wire logic        mst_busy,
    input wire logic        mst_done,
    input wire logic        mst_abort,
    input wire logic        tgt_wr,
    input wire logic        arb_enabled
);
    // All checks run on the bus clock.
    default clocking cb @(posedge clk); endclocking
    rst_drive_a: assert property (
        !rst_b |-> !ad_oe_n && ad_out == 32'h0 && !cbe_oe_n)
        else $error("bus not low in reset");
    rst_float_a: assert property (
        !rst_b |-> frame_oe_n && devsel_oe_n && memory_request_oe_n)
        else $error("control not floating in reset");
    rel_float_a: assert property (
        disable iff (!rst_b) $rose(rst_b) |-> ##2 ad_oe_n && cbe_oe_n)
        else $error("bus not floated on release");
    req_idle_a: assert property (
        disable iff (!rst_b) rst_b && $past(rst_b, 2)
        |-> !memory_request_oe_n && memory_request_n)
        else $error("memory request not inactive");
    park_win_a: assert property (
        disable iff (!rst_b) $rose(rst_b) && cpu_bus_request_n
        |-> ##[2:5] !ad_oe_n && ad_out == 32'h0 && !cbe_oe_n)
        else $error("no park in window");
    no_park_a: assert property (
        disable iff (!rst_b) $past(rst_b, 2) && !arb_enabled && !mst_busy
        && bridge_own_grant_n && $past(bridge_own_grant_n)
        && devsel_oe_n && $past(devsel_oe_n) |-> ad_oe_n)
        else $error("bus driven with arbiter off");
    ctl_float_a: assert property (
        disable iff (!rst_b) !mst_busy |-> frame_oe_n && irdy_oe_n)
        else $error("frame driven while idle");
    addr_low_a: assert property (
        disable iff (!rst_b) !frame_oe_n && !frame_out
        |-> ad_out[1:0] == 2'b00 && !ad_oe_n && !cbe_oe_n)
        else $error("address low bits not zero");
    // Main scenarios reached.
    cover property (mst_done && !mst_abort);
    cover property (mst_done && mst_abort);
    cover property (tgt_wr);
endmodule // prp_bus_park_chk
bind prp_bus_park prp_bus_park_chk u_chk (.*);
`default_nettype wire

// >>> bench/prp_far_tgt.sv
// Far-side target answering the block's master cycles.
// Assumes released control lines are pulled high by the bench.
`timescale 1ns/1ps
`default_nettype none
// ==============================================
// Partner target
// ==============================================
module prp_far_tgt (
    // Bus view.
    input  wire logic        clk,
    input  wire logic        frame_n,
    input  wire logic        irdy_n,
    input  wire logic [31:0] ad,
    input  wire logic [3:0]  cbe,
    // Behaviour knobs: silence and wait states.
    input  wire logic        mute,
    input  wire logic [2:0]  lag,
    // Responses and what was captured.
    output logic             trdy_n,
    output logic             devsel_n,
    output logic             drv,
    output logic [31:0]      rd,
    output logic [31:0]      got_addr,
    output logic [31:0]      got_data,
    output logic [3:0]       got_cmd
);
    logic [2:0] cnt;
    logic       act;
    logic       fl;
    initial {trdy_n, devsel_n, drv, act, fl} = 5'h19;
    // Claim, wait, then finish when both ready lines are low.
    always @(posedge clk) begin
        fl <= frame_n;
        if (fl && !frame_n && !act) begin
            got_addr <= ad;
            got_cmd  <= cbe;
            act      <= !mute;
            cnt      <= lag;
            rd       <= ad + 32'h11;
        end else if (act) begin
            devsel_n <= 1'b0;
            if (cnt != 3'h0) cnt <= cnt - 3'h1;
            else if (trdy_n) begin
                trdy_n <= 1'b0;
                drv    <= !got_cmd[0];
            end else if (!irdy_n) begin
                got_data <= ad;
                {trdy_n, devsel_n, drv, act} <= 4'hc;
            end
        end
    end
endmodule // prp_far_tgt
`default_nettype wire

// >>> core/prp_bus_park.v
// Primary-bus reset, strap sampling, parking, master and target drive.
// Assumes every bus pin is synchronous to clk; rst_b is the bus reset.
`timescale 1ns/1ps
`default_nettype none
`include "prp_regs.vh"

module prp_bus_park (
    // Clock and asynchronous bus reset.
    input  wire        clk,
    input  wire        rst_b,
    // Multiplexed address/data, command/enables and parity.
    input  wire [31:0] ad_in,
    output reg  [31:0] ad_out,
    output reg         ad_oe_n,
    input  wire [3:0]  cbe_in,
    output reg  [3:0]  cbe_out,
    output reg         cbe_oe_n,
    output reg         par_out,
    output reg         par_oe_n,
    // Transaction control lines, active low.
    input  wire        frame_in,
    output reg         frame_out,
    output reg         frame_oe_n,
    input  wire        irdy_in,
    output reg         irdy_out,
    output reg         irdy_oe_n,
    input  wire        trdy_in,
    output reg         trdy_out,
    output reg         trdy_oe_n,
    input  wire        stop_in,
    output reg         stop_out,
    output reg         stop_oe_n,
    input  wire        devsel_in,
    output reg         devsel_out,
    output reg         devsel_oe_n,
    // Memory and flush requests.
    output reg         memory_request_n,
    output reg         memory_request_oe_n,
    output reg         flush_request_n,
    output reg         flush_request_oe_n,
    // Arbitration requests and grants.
    input  wire        cpu_bus_request_n,
    input  wire [1:0]  master_request_n,
    input  wire        bridge_own_grant_n,
    output reg         cpu_bus_grant_n,
    output reg         cpu_bus_grant_oe_n,
    output reg         grant0_or_bridge_request_n,
    output reg         grant0_or_bridge_request_oe_n,
    output reg         grant1_or_resume_n,
    output reg         grant1_or_resume_oe_n,
    // User-side master request.
    input  wire        mst_start,
    input  wire        mst_write,
    input  wire [31:0] mst_addr,
    input  wire [3:0]  mst_cmd,
    input  wire [31:0] mst_wdata,
    input  wire [3:0]  mst_be_n,
    output reg         mst_busy,
    output reg         mst_done,
    output reg         mst_abort,
    output reg  [31:0] mst_rdata,
    // User-side target word and status.
    output reg  [31:0] tgt_word,
    output reg         tgt_wr,
    output reg         arb_enabled
);

    // Master states.
    localparam [3:0] M_IDLE  = 4'h1;
    localparam [3:0] M_ADDR  = 4'h2;
    localparam [3:0] M_DATA  = 4'h4;
    localparam [3:0] M_TURN  = 4'h8;
    // Target states.
    localparam [3:0] T_IDLE  = 4'h1;
    localparam [3:0] T_TURNA = 4'h2;
    localparam [3:0] T_DATA  = 4'h4;
    localparam [3:0] T_END   = 4'h8;
    // Grant selections.
    localparam [3:0] G_NONE  = 4'h0;
    localparam [3:0] G_OWN   = 4'h1;
    localparam [3:0] G_CPU   = 4'h2;
    localparam [3:0] G_R0    = 4'h4;
    localparam [3:0] G_R1    = 4'h8;

    wire        run;
    reg         strap_done;
    reg  [2:0]  rel_cnt;
    reg  [3:0]  m_state;
    reg  [3:0]  next_m_state;
    reg  [3:0]  t_state;
    reg  [3:0]  next_t_state;
    reg  [3:0]  gnt_sel;
    reg  [3:0]  next_gnt_sel;
    reg  [2:0]  m_cnt;
    reg  [31:0] m_addr;
    reg  [3:0]  m_cmd;
    reg  [31:0] m_wdata;
    reg  [3:0]  m_be_n;
    reg         m_wr;
    reg         t_wr;
    reg         frame_q;
    wire        bus_idle;
    wire        park_ok;
    wire        own_gnt;
    wire        tmo_hit;
    wire        addr_phase;
    wire        tgt_hit;
    wire        idle_drive;

    // Even parity over address/data and command/enables.
    function prp_parity;
        input [31:0] ad;
        input [3:0]  cbe;
        begin
            prp_parity = (^ad) ^ (^cbe);
        end
    endfunction

    // Merge written bytes into a word, lane n by enable n, active low.
    function [31:0] prp_merge;
        input [31:0] old_w;
        input [31:0] new_w;
        input [3:0]  be_n;
        integer      i;
        begin
            prp_merge = old_w;
            for (i = 0; i < 4; i = i + 1) begin
                if (!be_n[i]) begin
                    prp_merge[i*8 +: 8] = new_w[i*8 +: 8];
                end
            end
        end
    endfunction

    // =============================================================
    // Reset release and strap capture
    // =============================================================
    // Internal machines wait for the synchronised release.
    prp_rst_sync u_rst_sync (
        .clk    (clk),
        .rst_b  (rst_b),
        .srst_b (run)
    );

    // Sample the CPU request level once the release is seen.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_done  <= 1'b0;
            arb_enabled <= 1'b0;
            rel_cnt     <= 3'h0;
        end else begin
            if (run && !strap_done) begin
                strap_done  <= 1'b1;
                arb_enabled <= cpu_bus_request_n;
            end
            if (rel_cnt != `PRP_PARK_CLKS) begin
                rel_cnt <= rel_cnt + 3'h1;
            end
        end
    end

    // Parking may begin the fourth clock after release.
    assign park_ok    = strap_done && arb_enabled &&
                        (rel_cnt >= (`PRP_PARK_CLKS - 3'h1));
    // Idle means frame and initiator ready both sampled high.
    assign bus_idle   = frame_in && irdy_in;
    assign own_gnt    = arb_enabled ? (gnt_sel == G_OWN)
                                    : !bridge_own_grant_n;
    assign tmo_hit    = devsel_in && (m_cnt >= `PRP_DEVSEL_TMO);
    assign addr_phase = !frame_in && frame_q;
    assign tgt_hit    = ({ad_in[31:2], 2'b00} == `PRP_TGT_BASE) &&
                        ((cbe_in == `PRP_CMD_MRD) ||
                         (cbe_in == `PRP_CMD_MWR));

    // =============================================================
    // Arbiter and next-state decode
    // =============================================================
    // Fixed priority: own, CPU, request 0, request 1.
    always @* begin
        next_gnt_sel = gnt_sel;
        if (!arb_enabled || !strap_done) begin
            next_gnt_sel = G_NONE;
        end else if (bus_idle && m_state == M_IDLE) begin
            if (mst_busy) begin
                next_gnt_sel = G_OWN;
            end else if (!cpu_bus_request_n) begin
                next_gnt_sel = G_CPU;
            end else if (!master_request_n[0]) begin
                next_gnt_sel = G_R0;
            end else if (!master_request_n[1]) begin
                next_gnt_sel = G_R1;
            end else begin
                next_gnt_sel = G_NONE;
            end
        end
    end

    // Master sequence: one address phase, then one data phase.
    always @* begin
        next_m_state = m_state;
        case (m_state)
            M_IDLE: begin
                if (run && mst_busy && own_gnt && bus_idle &&
                    t_state == T_IDLE) begin
                    next_m_state = M_ADDR;
                end
            end
            M_ADDR: next_m_state = M_DATA;
            M_DATA: begin
                if (!trdy_in || !stop_in || tmo_hit) begin
                    next_m_state = M_TURN;
                end
            end
            M_TURN: next_m_state = M_IDLE;
            default: next_m_state = M_IDLE;
        endcase
    end

    // Target sequence with a turnaround clock before read data.
    always @* begin
        next_t_state = t_state;
        case (t_state)
            T_IDLE: begin
                if (run && addr_phase && tgt_hit && m_state == M_IDLE) begin
                    next_t_state = (cbe_in == `PRP_CMD_MRD) ? T_TURNA
                                                             : T_DATA;
                end
            end
            T_TURNA: next_t_state = T_DATA;
            T_DATA: begin
                if (!irdy_in) begin
                    next_t_state = T_END;
                end
            end
            T_END: next_t_state = T_IDLE;
            default: next_t_state = T_IDLE;
        endcase
    end

    // Drive low when idle and parked, or idle under own grant.
    assign idle_drive = (next_m_state == M_IDLE) &&
                        (next_t_state == T_IDLE) && bus_idle &&
                        (arb_enabled ?
                         (park_ok && (next_gnt_sel == G_NONE ||
                                      next_gnt_sel == G_OWN))
                         : (strap_done && !bridge_own_grant_n));

    // =============================================================
    // State registers and user side
    // =============================================================
    // Machines, request latch and target word; defaults on reset.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            m_state   <= M_IDLE;
            t_state   <= T_IDLE;
            gnt_sel   <= G_NONE;
            m_cnt     <= 3'h0;
            m_addr    <= 32'h00000000;
            m_cmd     <= 4'h0;
            m_wdata   <= 32'h00000000;
            m_be_n    <= 4'hf;
            m_wr      <= 1'b0;
            t_wr      <= 1'b0;
            frame_q   <= 1'b1;
            mst_busy  <= 1'b0;
            mst_done  <= 1'b0;
            mst_abort <= 1'b0;
            mst_rdata <= 32'h00000000;
            tgt_word  <= `PRP_TGT_RST;
            tgt_wr    <= 1'b0;
        end else if (run) begin
            m_state  <= next_m_state;
            t_state  <= next_t_state;
            gnt_sel  <= next_gnt_sel;
            frame_q  <= frame_in;
            mst_done <= 1'b0;
            tgt_wr   <= 1'b0;
            if (mst_start && !mst_busy) begin
                mst_busy <= 1'b1;
                m_addr   <= mst_addr;
                m_cmd    <= mst_cmd;
                m_wdata  <= mst_wdata;
                m_be_n   <= mst_be_n;
                m_wr     <= mst_write;
            end
            m_cnt <= (m_state == M_DATA) ? m_cnt + 3'h1 : 3'h0;
            // Completion latches read data and reports the outcome.
            if (m_state == M_DATA && next_m_state == M_TURN) begin
                mst_done  <= 1'b1;
                mst_abort <= trdy_in;
                if (!trdy_in && !m_wr) begin
                    mst_rdata <= ad_in;
                end
            end
            if (m_state == M_TURN) begin
                mst_busy <= 1'b0;
            end
            // Target records direction and accepts write bytes.
            if (t_state == T_IDLE && next_t_state != T_IDLE) begin
                t_wr <= (cbe_in == `PRP_CMD_MWR);
            end
            if (t_state == T_DATA && !irdy_in && t_wr) begin
                tgt_word <= prp_merge(tgt_word, ad_in, cbe_in);
                tgt_wr   <= 1'b1;
            end
        end
    end

    // =============================================================
    // Address/data, command/enable and parity drive
    // =============================================================
    // Reset drives low; release floats; then master, target or park.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ad_out   <= 32'h00000000;
            ad_oe_n  <= 1'b0;
            cbe_out  <= 4'h0;
            cbe_oe_n <= 1'b0;
            par_out  <= 1'b0;
            par_oe_n <= 1'b0;
        end else begin
            par_out  <= prp_parity(ad_out, cbe_out);
            par_oe_n <= ad_oe_n;
            if (run && next_m_state == M_ADDR) begin
                ad_out   <= {m_addr[31:2], 2'b00};
                ad_oe_n  <= 1'b0;
                cbe_out  <= m_cmd;
                cbe_oe_n <= 1'b0;
            end else if (run && next_m_state == M_DATA) begin
                ad_out   <= m_wr ? m_wdata : 32'h00000000;
                ad_oe_n  <= !m_wr;
                cbe_out  <= m_be_n;
                cbe_oe_n <= 1'b0;
            end else if (run && next_t_state == T_DATA && !t_wr &&
                         t_state != T_IDLE) begin
                ad_out   <= tgt_word;
                ad_oe_n  <= 1'b0;
                cbe_out  <= 4'h0;
                cbe_oe_n <= 1'b1;
            end else if (run && idle_drive) begin
                ad_out   <= 32'h00000000;
                ad_oe_n  <= 1'b0;
                cbe_out  <= 4'h0;
                cbe_oe_n <= 1'b0;
            end else begin
                ad_out   <= 32'h00000000;
                ad_oe_n  <= 1'b1;
                cbe_out  <= 4'h0;
                cbe_oe_n <= 1'b1;
            end
        end
    end

    // =============================================================
    // Transaction control drive
    // =============================================================
    // Controls float in reset and drive only within own roles.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            frame_out   <= 1'b1;
            frame_oe_n  <= 1'b1;
            irdy_out    <= 1'b1;
            irdy_oe_n   <= 1'b1;
            trdy_out    <= 1'b1;
            trdy_oe_n   <= 1'b1;
            stop_out    <= 1'b1;
            stop_oe_n   <= 1'b1;
            devsel_out  <= 1'b1;
            devsel_oe_n <= 1'b1;
        end else begin
            frame_out  <= !(run && next_m_state == M_ADDR);
            irdy_out   <= !(run && next_m_state == M_DATA);
            frame_oe_n <= !run || next_m_state == M_IDLE;
            irdy_oe_n  <= !run || next_m_state == M_IDLE;
            devsel_out <= !(run && (next_t_state == T_TURNA ||
                                    next_t_state == T_DATA));
            trdy_out   <= !(run && next_t_state == T_DATA);
            stop_out   <= 1'b1;
            devsel_oe_n <= !run || next_t_state == T_IDLE;
            trdy_oe_n   <= !run || next_t_state == T_IDLE;
            stop_oe_n   <= !run || next_t_state == T_IDLE;
        end
    end

    // =============================================================
    // Requests and grants drive
    // =============================================================
    // Float in reset; inactive requests and scheme grants after.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            memory_request_n              <= 1'b1;
            memory_request_oe_n           <= 1'b1;
            flush_request_n               <= 1'b1;
            flush_request_oe_n            <= 1'b1;
            cpu_bus_grant_n               <= 1'b1;
            cpu_bus_grant_oe_n            <= 1'b1;
            grant0_or_bridge_request_n    <= 1'b1;
            grant0_or_bridge_request_oe_n <= 1'b1;
            grant1_or_resume_n            <= 1'b1;
            grant1_or_resume_oe_n         <= 1'b1;
        end else begin
            memory_request_n    <= 1'b1;
            memory_request_oe_n <= 1'b0;
            flush_request_n     <= 1'b1;
            flush_request_oe_n  <= 1'b0;
            if (strap_done && arb_enabled) begin
                cpu_bus_grant_n               <= !next_gnt_sel[1];
                cpu_bus_grant_oe_n            <= 1'b0;
                grant0_or_bridge_request_n    <= !next_gnt_sel[2];
                grant0_or_bridge_request_oe_n <= 1'b0;
                grant1_or_resume_n            <= !next_gnt_sel[3];
                grant1_or_resume_oe_n         <= 1'b0;
            end else if (strap_done) begin
                cpu_bus_grant_n               <= 1'b1;
                cpu_bus_grant_oe_n            <= 1'b1;
                grant0_or_bridge_request_n    <= !mst_busy;
                grant0_or_bridge_request_oe_n <= 1'b0;
                grant1_or_resume_n            <= 1'b1;
                grant1_or_resume_oe_n         <= 1'b0;
            end else begin
                cpu_bus_grant_n               <= 1'b1;
                cpu_bus_grant_oe_n            <= 1'b1;
                grant0_or_bridge_request_n    <= 1'b1;
                grant0_or_bridge_request_oe_n <= 1'b1;
                grant1_or_resume_n            <= 1'b1;
                grant1_or_resume_oe_n         <= 1'b1;
            end
        end
    end

endmodule // prp_bus_park

`default_nettype wire

// >>> core/prp_regs.vh
// Constants for the primary-bus reset and bus-parking block.
// Assumes inclusion by bare name from the core design files.
`ifndef PRP_REGS_VH
`define PRP_REGS_VH

// =============================================================
// Clock and reset timing
// =============================================================
`define PRP_CLK_MHZ       20
`define PRP_RST_MIN_NS    1000
`define PRP_RST_MIN_CLKS  ((`PRP_RST_MIN_NS * `PRP_CLK_MHZ + 999) / 1000)
`define PRP_PARK_CLKS     3'h4
`define PRP_DEVSEL_TMO    3'h5

// =============================================================
// Bus commands and reset values
// =============================================================
`define PRP_CMD_MRD       4'h6
`define PRP_CMD_MWR       4'h7
`define PRP_TGT_RST       32'h00000000
`define PRP_TGT_BASE      32'h00001000

`endif

// >>> core/prp_rst_sync.v
// Reset release synchroniser for the primary-bus block.
// Assumes rst_b may change at any time relative to clk.
`timescale 1ns/1ps
`default_nettype none

// =============================================================
// Two-stage reset synchroniser
// =============================================================
module prp_rst_sync (
    // Clock and raw reset.
    input  wire clk,
    input  wire rst_b,
    // Synchronised release, asserted asynchronously.
    output reg  srst_b
);

    reg stage1;

    // Assertion acts at once, release passes two flip-flops.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= 1'b0;
            srst_b <= 1'b0;
        end else begin
            stage1 <= 1'b1;
            srst_b <= stage1;
        end
    end

endmodule // prp_rst_sync

`default_nettype wire
